/* include/pmss_pkg.sv */
package pmss_pkg;
	// Phase count and counter widths
	localparam int NUM_PHASES = 6;
	localparam int CNT_W = 8;
	// Sequencer clock rate
	localparam int CLK_KHZ = 25000;
	// Switching period in system clocks (100 kHz oscillator)
	localparam logic [7:0] PWM_PERIOD_CYC = 8'hfa;
	localparam int OSC_PERIOD_US = 10;
	// Minimum on-time of a refresh pulse, in system clocks
	localparam logic [7:0] MIN_ON_CYC = 8'h0a;
	// Start-up and dropped-phase refresh lengths, in oscillator cycles
	localparam logic [3:0] START_REFRESH_TICKS = 4'h8;
	localparam logic [3:0] DROP_REFRESH_TICKS = 4'h4;
	// Dropped-phase refresh interval
	localparam int REFRESH_INT_US = 500;
	localparam logic [6:0] REFRESH_INT_TICKS =
		7'(REFRESH_INT_US / OSC_PERIOD_US);
	// Soft-on duration and ramp resolution
	localparam int SOFTON_MS = 100;
	localparam int SOFTON_STEPS = 256;
	localparam int SOFTON_CYC = SOFTON_MS * CLK_KHZ;
	localparam int SOFTON_STEP_CYC = SOFTON_CYC / SOFTON_STEPS;
	localparam logic [7:0] SOFTON_FULL = 8'hff;
	// Duty reduction per oscillator cycle while dropping
	localparam logic [7:0] DROP_STEP_CYC = 8'h04;
	// Reset values
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [5:0] ZERO6 = 6'h00;
endpackage : pmss_pkg

/* rtl/pmss_phase_stage.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// One phase output: high for hs clocks, low for ls clocks, else mid level
module pmss_phase_stage (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_cycle_start,
	input wire logic i_park,
	input wire logic [7:0] i_hs_cnt,
	input wire logic [7:0] i_ls_cnt,
	output logic o_pwm,
	output logic o_mid
);
	logic [7:0] pos;
	logic [8:0] hs_ls;
	logic next_pwm;
	logic next_mid;

	// Position inside the switching period, restarted by the oscillator
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_cycle_start) begin
			pos <= pmss_pkg::ZERO8;
		end else if (pos != 8'hff) begin
			pos <= pos + 8'h01;
		end
	end

	assign hs_ls = {1'b0, i_hs_cnt} + {1'b0, i_ls_cnt};

	// Tri-level decode; mid keeps both FETs of the phase off
	always_comb begin
		next_pwm = 1'b0;
		next_mid = 1'b1;
		if (!i_park) begin
			if ({1'b0, pos} < {1'b0, i_hs_cnt}) begin
				next_pwm = 1'b1;
				next_mid = 1'b0;
			end else if ({1'b0, pos} < hs_ls) begin
				next_mid = 1'b0;
			end
		end
	end

	// Registered so the pins never glitch on decode
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_pwm <= 1'b0;
			o_mid <= 1'b1;
		end else begin
			o_pwm <= next_pwm;
			o_mid <= next_mid;
		end
	end
endmodule : pmss_phase_stage

/* rtl/pmss_sequencer.sv */
`timescale 1ns/1ps
module pmss_sequencer #(
	parameter int P_SOFTON_STEP_CYC = pmss_pkg::SOFTON_STEP_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_osc_tick,
	input wire logic i_pwr_en_above_rise,
	input wire logic i_pwr_en_below_fall,
	input wire logic i_prebias_done,
	input wire logic i_comp_above_offset,
	input wire logic i_ss_at_clamp,
	input wire logic i_drop_select,
	input wire logic i_load_low,
	input wire logic [5:0] i_drop_mask,
	input wire logic [7:0] i_duty,
	output logic o_driver_enable_out,
	output logic o_ss_prebias,
	output logic o_ss_done,
	output logic [5:0] o_phase_pwm_out,
	output logic [5:0] o_phase_pwm_mid,
	output logic [5:0] o_phase_dropped
);
	typedef enum logic [2:0] {
		ST_OFF, ST_PREBIAS, ST_REFRESH, ST_WAIT_COMP,
		ST_SOFTSTART, ST_SOFTON, ST_RUN
	} pmss_state_t;

	pmss_state_t state;
	logic [3:0] tick_cnt;
	logic [31:0] step_cnt;
	logic [7:0] sync_frac;
	logic [7:0] drop_duty;
	logic dropping;
	logic [6:0] int_cnt;
	logic burst;
	logic [7:0] duty_clip;
	logic [7:0] off_time;
	logic [15:0] ls_prod;
	logic [7:0] ls_common;

	////////////////////////////////////////////////////////////////////////
	// Sequencer state; reset is the chip enable falling
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state <= ST_OFF;
		end else if (state != ST_OFF && i_pwr_en_below_fall) begin
			state <= ST_OFF;
		end else begin
			case (state)
			ST_OFF: begin
				if (i_pwr_en_above_rise) begin
					state <= ST_PREBIAS;
				end
			end
			ST_PREBIAS: begin
				if (i_prebias_done) begin
					state <= ST_REFRESH;
				end
			end
			ST_REFRESH: begin
				// Leave on the tick that closes the eighth pulse period
				if (i_osc_tick &&
					tick_cnt == pmss_pkg::START_REFRESH_TICKS) begin
					state <= ST_WAIT_COMP;
				end
			end
			ST_WAIT_COMP: begin
				if (i_comp_above_offset) begin
					state <= ST_SOFTSTART;
				end
			end
			ST_SOFTSTART: begin
				if (i_ss_at_clamp) begin
					state <= ST_SOFTON;
				end
			end
			ST_SOFTON: begin
				if (sync_frac == pmss_pkg::SOFTON_FULL) begin
					state <= ST_RUN;
				end
			end
			ST_RUN: begin
				state <= ST_RUN;
			end
			default: begin
				state <= ST_OFF;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Driver enable and status flags
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_driver_enable_out <= 1'b0;
			o_ss_prebias <= 1'b0;
			o_ss_done <= 1'b0;
		end else begin
			// Drivers follow the pins only after prebias finishes
			o_driver_enable_out <= state inside {ST_REFRESH, ST_WAIT_COMP,
				ST_SOFTSTART, ST_SOFTON, ST_RUN} &&
				!i_pwr_en_below_fall;
			o_ss_prebias <= (state == ST_PREBIAS);
			o_ss_done <= state inside {ST_SOFTON, ST_RUN};
		end
	end

	// Oscillator cycle count for the start-up refresh burst
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || state != ST_REFRESH) begin
			tick_cnt <= 4'h0;
		end else if (i_osc_tick) begin
			tick_cnt <= tick_cnt + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Soft-on ramp of the synchronous fraction, 256 steps
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !(state inside {ST_SOFTON, ST_RUN})) begin
			step_cnt <= 32'h0;
			sync_frac <= pmss_pkg::ZERO8;
		end else if (sync_frac != pmss_pkg::SOFTON_FULL) begin
			if (step_cnt >= 32'(P_SOFTON_STEP_CYC - 1)) begin
				step_cnt <= 32'h0;
				sync_frac <= sync_frac + 8'h01;
			end else begin
				step_cnt <= step_cnt + 32'h1;
			end
		end
	end

	// Low-side time: none in soft-start, scaled in soft-on, full after
	always_comb begin
		duty_clip = (i_duty > pmss_pkg::PWM_PERIOD_CYC) ?
			pmss_pkg::PWM_PERIOD_CYC : i_duty;
		off_time = pmss_pkg::PWM_PERIOD_CYC - duty_clip;
		ls_prod = 16'(off_time) * 16'(sync_frac);
		if (state == ST_RUN) begin
			ls_common = off_time;
		end else if (state == ST_SOFTON) begin
			ls_common = ls_prod[15:8];
		end else begin
			ls_common = pmss_pkg::ZERO8;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase dropping: duty shrinks per oscillator cycle, then held
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || state != ST_RUN || !i_drop_select ||
			!i_load_low) begin
			// Load rise brings all phases back
			dropping <= 1'b0;
			drop_duty <= pmss_pkg::ZERO8;
			o_phase_dropped <= pmss_pkg::ZERO6;
		end else if (o_phase_dropped == pmss_pkg::ZERO6 && !dropping) begin
			dropping <= 1'b1;
			drop_duty <= duty_clip;
		end else if (dropping && i_osc_tick) begin
			if (drop_duty <= pmss_pkg::DROP_STEP_CYC) begin
				dropping <= 1'b0;
				drop_duty <= pmss_pkg::ZERO8;
				o_phase_dropped <= i_drop_mask;
			end else begin
				drop_duty <= drop_duty - pmss_pkg::DROP_STEP_CYC;
			end
		end else begin
			// Dropped set holds while load stays low
			o_phase_dropped <= o_phase_dropped;
		end
	end

	// Interval and burst timing for dropped phases, in oscillator cycles
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || o_phase_dropped == pmss_pkg::ZERO6) begin
			int_cnt <= 7'h0;
			burst <= 1'b0;
		end else if (i_osc_tick) begin
			if (int_cnt == pmss_pkg::REFRESH_INT_TICKS - 7'h1) begin
				int_cnt <= 7'h0;
				burst <= 1'b1;
			end else begin
				int_cnt <= int_cnt + 7'h1;
				if (int_cnt == 7'(pmss_pkg::DROP_REFRESH_TICKS) - 7'h1) begin
					burst <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-phase drive selection and output stage
	genvar g;
	generate
		for (g = 0; g < pmss_pkg::NUM_PHASES; g++) begin : g_phase
			logic park;
			logic [7:0] hs;
			logic [7:0] ls;
			always_comb begin
				park = 1'b1;
				hs = pmss_pkg::ZERO8;
				ls = pmss_pkg::ZERO8;
				case (state)
				ST_REFRESH: begin
					park = 1'b0;
					ls = pmss_pkg::MIN_ON_CYC;
				end
				ST_SOFTSTART, ST_SOFTON, ST_RUN: begin
					park = 1'b0;
					hs = duty_clip;
					ls = ls_common;
					if (o_phase_dropped[g]) begin
						park = !burst;
						hs = pmss_pkg::ZERO8;
						ls = pmss_pkg::MIN_ON_CYC;
					end else if (dropping && i_drop_mask[g]) begin
						hs = drop_duty;
					end
				end
				default: begin
					park = 1'b1;
				end
				endcase
			end
			pmss_phase_stage u_stage (
				.i_clk_sys(i_clk_sys),
				.i_sys_rst(i_sys_rst),
				.i_cycle_start(i_osc_tick),
				.i_park(park),
				.i_hs_cnt(hs),
				.i_ls_cnt(ls),
				.o_pwm(o_phase_pwm_out[g]),
				.o_mid(o_phase_pwm_mid[g])
			);
		end
	endgenerate
endmodule : pmss_sequencer

/* sim/pmss_seq_asserts.sv */
`timescale 1ns/1ps
// Port watcher; pin answers lag their cause by two edges
module pmss_seq_chk (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_pwr_en_above_rise,
	input wire logic i_pwr_en_below_fall,
	input wire logic i_prebias_done,
	input wire logic i_comp_above_offset,
	input wire logic i_ss_at_clamp,
	input wire logic i_load_low,
	input wire logic o_driver_enable_out,
	input wire logic o_ss_prebias,
	input wire logic o_ss_done,
	input wire logic [5:0] o_phase_pwm_out,
	input wire logic [5:0] o_phase_pwm_mid,
	input wire logic [5:0] o_phase_dropped
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	logic comp_seen;
	////////////////////////////////////////////////////////////////////////////
	// Go-ahead memory; cleared with the drivers so a restart must ask again
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !o_driver_enable_out)
			comp_seen <= 1'b0;
		else if (i_comp_above_offset)
			comp_seen <= 1'b1;
	end
	sequence s_held_off;
		i_pwr_en_below_fall [*3];
	endsequence
	sequence s_prebias_end;
		$past(o_ss_prebias) && $past(i_prebias_done, 2);
	endsequence
	property p_off_state;
		s_held_off |=> !o_driver_enable_out && o_phase_pwm_mid == 6'h3f;
	endproperty
	a_off_state: assert property (p_off_state)
		else $error("outputs not parked while enable low");
	property p_prebias;
		$rose(o_ss_prebias) |-> $past(i_pwr_en_above_rise, 2);
	endproperty
	a_prebias: assert property (p_prebias)
		else $error("prebias without enable rise");
	property p_drv_on;
		$rose(o_driver_enable_out) |-> s_prebias_end;
	endproperty
	a_drv_on: assert property (p_drv_on)
		else $error("driver enable not tied to prebias end");
	property p_refresh;
		$rose(o_driver_enable_out) |->
			##[1:300] (o_phase_pwm_mid == 6'h00 && o_phase_pwm_out == 6'h00);
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("no low refresh pulse after driver enable");
	property p_gate;
		(o_phase_pwm_out & ~o_phase_pwm_mid) != 6'h00 |-> comp_seen;
	endproperty
	a_gate: assert property (p_gate)
		else $error("high side on before compensation ready");
	property p_ss_done;
		$rose(o_ss_done) |-> $past(i_ss_at_clamp, 2) && o_driver_enable_out;
	endproperty
	a_ss_done: assert property (p_ss_done)
		else $error("soft-start done without clamp");
	property p_dropped_quiet;
		$past(o_phase_dropped, 3) != 6'h00 |-> (o_phase_dropped &
			$past(o_phase_dropped, 3) & o_phase_pwm_out &
			~o_phase_pwm_mid) == 6'h00;
	endproperty
	a_dropped_quiet: assert property (p_dropped_quiet)
		else $error("dropped phase drove high side");
	property p_drop_hold;
		(o_phase_dropped != 6'h00 && i_load_low) ##1 i_load_low
			|-> $stable(o_phase_dropped);
	endproperty
	a_drop_hold: assert property (p_drop_hold)
		else $error("phase count moved under steady load");
endmodule : pmss_seq_chk

/* sim/pmss_fet_drv_model.sv */
`timescale 1ns/1ps
// Gate driver pair per phase; mid level turns both FETs off
module pmss_fet_drv_model (
	input wire logic i_en,
	input wire logic [5:0] i_pwm,
	input wire logic [5:0] i_mid,
	output logic [5:0] o_hs_on,
	output logic [5:0] o_ls_on
);
	// Disabled drivers keep both FETs off whatever the inputs show
	assign o_hs_on = {6{i_en}} & ~i_mid & i_pwm;
	assign o_ls_on = {6{i_en}} & ~i_mid & ~i_pwm;
endmodule : pmss_fet_drv_model

/* sim/pmss_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	errors++; $display("ERROR %0t got %0h exp %0h", $time, got, exp); end end
module pmss_sequencer_tb;
	logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_osc_tick = 1'b0;
	logic i_pwr_en_above_rise = 1'b0, i_pwr_en_below_fall = 1'b1;
	logic i_prebias_done = 1'b0, i_comp_above_offset = 1'b0;
	logic i_ss_at_clamp = 1'b0, i_drop_select = 1'b0, i_load_low = 1'b0;
	logic [5:0] i_drop_mask = 6'h00, hs_on, ls_on;
	logic [7:0] i_duty = 8'h00;
	logic o_driver_enable_out, o_ss_prebias, o_ss_done;
	logic [5:0] o_phase_pwm_out, o_phase_pwm_mid, o_phase_dropped;
	int errors = 0, comparisons = 0, tick_cnt = 0, n_hs, n_ls;
	// Short soft-on steps keep the run brief
	pmss_sequencer #(.P_SOFTON_STEP_CYC(2)) dut (.i_clk_sys, .i_sys_rst,
		.i_osc_tick, .i_pwr_en_above_rise, .i_pwr_en_below_fall,
		.i_prebias_done, .i_comp_above_offset, .i_ss_at_clamp, .i_drop_select,
		.i_load_low, .i_drop_mask, .i_duty, .o_driver_enable_out, .o_ss_prebias,
		.o_ss_done, .o_phase_pwm_out, .o_phase_pwm_mid, .o_phase_dropped);
	pmss_fet_drv_model u_drv (.i_en(o_driver_enable_out),
		.i_pwm(o_phase_pwm_out), .i_mid(o_phase_pwm_mid), .o_hs_on(hs_on),
		.o_ls_on(ls_on));
	////////////////////////////////////////////////////////////////////////////
	// Clock and a 250-clock oscillator tick
	always #20 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		tick_cnt <= (tick_cnt == 249) ? 0 : tick_cnt + 1;
		i_osc_tick <= (tick_cnt == 249);
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : step
	// FET on-cycles of the chosen phases over n clocks
	task automatic count(input int n, input logic [5:0] sel);
		n_hs = 0;
		n_ls = 0;
		repeat (n) begin
			step(1);
			n_hs += int'(|(hs_on & sel));
			n_ls += int'(|(ls_on & sel));
		end
	endtask : count
	task automatic t_off;
		i_duty = 8'h64;
		i_drop_mask = 6'h30;
		count(20, 6'h3f);
		`CHK(o_driver_enable_out, 1'b0)
		`CHK(o_phase_pwm_mid, 6'h3f)
		`CHK(n_hs + n_ls, 0)
	endtask : t_off
	task automatic t_start;
		i_pwr_en_below_fall = 1'b0;
		i_pwr_en_above_rise = 1'b1;
		step(3);
		`CHK(o_ss_prebias, 1'b1)
		i_prebias_done = 1'b1;
		step(1);
		`CHK(o_driver_enable_out, 1'b0)
		step(1);
		`CHK(o_driver_enable_out, 1'b1)
		count(2500, 6'h01);
		`CHK(n_ls, 80)
		`CHK(n_hs, 0)
	endtask : t_start
	task automatic t_soft;
		i_comp_above_offset = 1'b1;
		step(260);
		count(250, 6'h01);
		`CHK(n_hs, 100)
		`CHK(n_ls, 0)
		i_ss_at_clamp = 1'b1;
		step(1);
		`CHK(o_ss_done, 1'b0)
		step(1);
		`CHK(o_ss_done, 1'b1)
		step(100);
		count(250, 6'h01);
		`CHK(n_ls inside {[1:149]}, 1'b1)
		step(300);
		count(250, 6'h01);
		`CHK(n_ls, 150)
	endtask : t_soft
	task automatic t_drop;
		i_drop_select = 1'b1;
		i_load_low = 1'b1;
		// Mid-way through dropping the high side is shorter than duty
		step(2000);
		count(250, 6'h20);
		`CHK(n_hs inside {[1:99]}, 1'b1)
		for (int k = 0; k < 8000 && o_phase_dropped !== 6'h30; k++)
			step(1);
		`CHK(o_phase_dropped, 6'h30)
		step(270);
		count(13750, 6'h20);
		`CHK(n_hs, 0)
		`CHK(n_ls, 40)
		`CHK(o_phase_dropped, 6'h30)
		i_load_low = 1'b0;
		step(800);
		`CHK(o_phase_dropped, 6'h00)
	endtask : t_drop
	task automatic t_reset;
		i_sys_rst = 1'b1;
		step(2);
		i_sys_rst = 1'b0;
		step(1);
		`CHK(o_driver_enable_out, 1'b0)
		`CHK(o_phase_pwm_mid, 6'h3f)
		`CHK(o_ss_done, 1'b0)
	endtask : t_reset
	task automatic complete_run;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	// Main sequence, then a watchdog well past the expected 25k clocks
	initial begin
		step(5);
		i_sys_rst = 1'b0;
		t_off();
		t_start();
		t_soft();
		t_drop();
		t_reset();
		complete_run();
	end
	initial begin
		step(60000);
		errors++;
		complete_run();
	end
endmodule : pmss_sequencer_tb
bind pmss_sequencer pmss_seq_chk u_chk (.i_clk_sys, .i_sys_rst,
	.i_pwr_en_above_rise, .i_pwr_en_below_fall, .i_prebias_done,
	.i_comp_above_offset, .i_ss_at_clamp, .i_load_low, .o_driver_enable_out,
	.o_ss_prebias, .o_ss_done, .o_phase_pwm_out, .o_phase_pwm_mid,
	.o_phase_dropped);
